// file: shared/fsec_pkg.sv
// Package of constants and types for the flash sequencing host controller
package fsec_pkg;

    // Flash command codes
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_ERASE_GO     = 8'hd0;
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;

    // Status bit positions on the flash data bus
    localparam int SB_IDLE     = 7;
    localparam int SB_ERASE    = 5;
    localparam int SB_PROG     = 4;
    localparam int SB_SUPPLY   = 3;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_DATA   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RDATA  = 8'h10;

    // Control register fields
    localparam int CF_GO       = 0;
    localparam int CF_OP_LSB   = 1;
    localparam int CF_PWRDN    = 4;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // Timing, 250 MHz clock
    localparam int CLK_PS        = 4000;
    localparam int T_WP_NS       = 70;
    localparam int T_WPH_NS      = 30;
    localparam int T_RC_NS       = 100;
    localparam int T_RP_NS       = 150;
    localparam int T_RWH_NS      = 1000;
    localparam int CYC_WP  = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CYC_WPH = (T_WPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CYC_RC  = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CYC_RP  = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CYC_RWH = (T_RWH_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // Host operations selected by software
    typedef enum logic [2:0]
    {
        FSEC_OP_PROGRAM = 3'd0,
        FSEC_OP_ERASE   = 3'd1,
        FSEC_OP_CLEAR   = 3'd2,
        FSEC_OP_READ    = 3'd3,
        FSEC_OP_STATUS  = 3'd4
    } fsec_op_e;

    // Error decode of the three error flags
    typedef enum logic [2:0]
    {
        FSEC_ERR_NONE,
        FSEC_ERR_SUPPLY,
        FSEC_ERR_PROG,
        FSEC_ERR_PROG_SUPPLY,
        FSEC_ERR_ERASE,
        FSEC_ERR_ERASE_SUPPLY,
        FSEC_ERR_SEQ,
        FSEC_ERR_SEQ_ALL
    } fsec_err_e;

    // Flash pin outputs travelling together
    typedef struct packed
    {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic        reset_powerdown_n;
        logic [18:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe_n;
    } fsec_pins_s;

endpackage

// file: verilog/fsec_ctrl.sv
// Host controller that sequences flash commands, polls status and decodes errors
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module fsec_ctrl
    import fsec_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output var  logic        s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output var  logic        s_wready,
    output var  logic [1:0]  s_bresp,
    output var  logic        s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output var  logic        s_arready,
    output var  logic [31:0] s_rdata,
    output var  logic [1:0]  s_rresp,
    output var  logic        s_rvalid,
    input  wire logic        s_rready,
    // Flash pins
    output var  fsec_pins_s  flash_pins,
    input  wire logic [15:0] flash_dq_in
);

    // Sequencer states
    typedef enum logic [3:0]
    {
        S_PWRUP, S_IDLE, S_WR_LO, S_WR_HI, S_RD_LO, S_NEXT, S_PDOWN, S_WAKE
    } fsec_state_e;

    fsec_state_e  state_r;                 // Sequencer state
    logic [15:0]  dq_s1_r;                 // Data synchroniser stage 1
    logic [15:0]  dq_s2_r;                 // Data synchroniser stage 2
    logic [18:0]  addr_r;                  // Target address register
    logic [15:0]  data_r;                  // Program data register
    logic [2:0]   op_r;                    // Operation in progress
    logic         pwrdn_r;                 // Power-down request
    logic         busy_r;                  // Operation under way
    logic         done_r;                  // Sticky operation done
    logic [7:0]   stat_r;                  // Last flash status byte
    logic [15:0]  rdata_r;                 // Last array read word
    logic [1:0]   step_r;                  // Bus cycle index in sequence
    logic [7:0]   cnt_r;                   // Timing counter
    logic [7:0]   cmd_r;                   // Byte being written to flash
    logic         rd_only_r;               // Current phase is the status poll of a program or erase
    logic         aw_got_r;                // Write address captured
    logic         w_got_r;                 // Write data captured
    logic [7:0]   awaddr_r;                // Captured write address
    logic [31:0]  wdata_r;                 // Captured write data
    logic         wr_fire;                 // Register write this cycle

    // Error decode of erase, program, supply flags
    function automatic fsec_err_e err_decode(input logic [7:0] s);
        return fsec_err_e'({s[SB_ERASE], s[SB_PROG], s[SB_SUPPLY]});
    endfunction

    assign wr_fire = aw_got_r && w_got_r && !s_bvalid;

    // Synchronise the flash data bus
    always_ff @(posedge aclk)
    begin
        dq_s1_r <= flash_dq_in;
        dq_s2_r <= dq_s1_r;
    end

    // AXI write channel capture and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= 2'b00;
            awaddr_r  <= 8'h00;
            wdata_r   <= RST_ZERO;
        end
        else
        begin
            s_awready <= !aw_got_r && !s_awready;
            s_wready  <= !w_got_r && !s_wready;
            // Capture address
            if (s_awvalid && s_awready)
            begin
                aw_got_r  <= 1'b1;
                awaddr_r  <= s_awaddr;
                s_awready <= 1'b0;
            end
            // Capture data
            if (s_wvalid && s_wready)
            begin
                w_got_r  <= 1'b1;
                wdata_r  <= s_wdata;
                s_wready <= 1'b0;
            end
            // Respond once both arrived
            if (wr_fire)
            begin
                s_bvalid <= 1'b1;
                s_bresp  <= (awaddr_r <= OFS_RDATA && awaddr_r[1:0] == 2'b00) ? 2'b00 : 2'b10;
            end
            else if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= RST_ZERO;
            s_rresp   <= 2'b00;
        end
        else if (s_rvalid)
        begin
            s_arready <= 1'b0;
            if (s_rready)
                s_rvalid <= 1'b0;
        end
        else if (s_arvalid && s_arready)
        begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rresp   <= 2'b00;
            case (s_araddr)
                OFS_CTRL:   s_rdata <= {27'd0, pwrdn_r, op_r, busy_r};
                OFS_ADDR:   s_rdata <= {13'd0, addr_r};
                OFS_DATA:   s_rdata <= {16'd0, data_r};
                // Status: decoded error, done, busy, raw flash status
                OFS_STATUS: s_rdata <= {19'd0, err_decode(stat_r), done_r, busy_r, stat_r};
                OFS_RDATA:  s_rdata <= {16'd0, rdata_r};
                default:
                begin
                    s_rdata <= RST_ZERO;
                    s_rresp <= 2'b10;
                end
            endcase
        end
        else
            s_arready <= 1'b1;
    end

    // Software-written registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_r  <= 19'd0;
            data_r  <= 16'd0;
            op_r    <= 3'd0;
            pwrdn_r <= 1'b0;
        end
        else if (wr_fire)
        begin
            case (awaddr_r)
                OFS_CTRL:
                begin
                    if (s_wstrb[0])
                    begin
                        if (!busy_r)
                            op_r <= wdata_r[CF_OP_LSB +: 3];
                        pwrdn_r <= wdata_r[CF_PWRDN];
                    end
                end
                OFS_ADDR: addr_r <= wdata_r[18:0];
                OFS_DATA: data_r <= wdata_r[15:0];
                default:  addr_r <= addr_r;
            endcase
        end
    end

    // Flash bus sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r    <= S_PWRUP;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            stat_r     <= 8'h00;
            rdata_r    <= 16'd0;
            step_r     <= 2'd0;
            cnt_r      <= 8'd0;
            cmd_r      <= 8'h00;
            rd_only_r  <= 1'b0;
            flash_pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_powerdown_n: 1'b0,
                            addr: 19'd0, dq_out: 16'd0, dq_oe_n: 1'b1};
        end
        else
        begin
            if (cnt_r != 8'd0)
                cnt_r <= cnt_r - 8'd1;
            case (state_r)
                // Hold reset pin low through power-up, then let device settle
                S_PWRUP:
                begin
                    flash_pins.reset_powerdown_n <= 1'b0;
                    cnt_r   <= 8'(CYC_RP);
                    state_r <= S_WAKE;
                end
                S_WAKE:
                begin
                    if (cnt_r == 8'd1)
                    begin
                        // Device returns in array read with clear status
                        flash_pins.reset_powerdown_n <= 1'b1;
                        cnt_r   <= 8'(CYC_RWH);
                        state_r <= S_NEXT;
                        step_r  <= 2'd3;
                    end
                end
                S_IDLE:
                begin
                    flash_pins.ce_n <= 1'b1;
                    if (pwrdn_r)
                    begin
                        // Reset pin low: deep power-down, aborts device activity
                        flash_pins.reset_powerdown_n <= 1'b0;
                        cnt_r   <= 8'(CYC_RP);
                        state_r <= S_PDOWN;
                    end
                    else if (wr_fire && awaddr_r == OFS_CTRL && s_wstrb[0] && wdata_r[CF_GO])
                    begin
                        busy_r <= 1'b1;
                        done_r <= 1'b0;
                        step_r <= 2'd0;
                        state_r <= S_NEXT;
                    end
                end
                S_PDOWN:
                begin
                    if (!pwrdn_r && cnt_r == 8'd0)
                        state_r <= S_WAKE;
                    cnt_r <= (cnt_r == 8'd0) ? 8'd2 : cnt_r - 8'd1;
                end
                // Choose the next bus cycle of the running operation
                S_NEXT:
                begin
                    if (cnt_r == 8'd0 || cnt_r == 8'd1)
                    begin
                        state_r   <= S_WR_LO;
                        rd_only_r <= 1'b0;
                        cnt_r     <= 8'(CYC_WP);
                        flash_pins.ce_n <= 1'b0;
                        // Finished: done is raised only as the sequencer returns to idle,
                        // so a GO written right after software sees done is dropped only during power-down and the wake that follows it
                        if (step_r == 2'd3)
                        begin
                            flash_pins.ce_n <= 1'b1;
                            state_r <= S_IDLE;
                            busy_r  <= 1'b0;
                            done_r  <= done_r | busy_r;
                        end
                        else
                        case (fsec_op_e'(op_r))
                            FSEC_OP_PROGRAM, FSEC_OP_ERASE:
                            begin
                                // Setup, then data or confirm, then poll idle flag
                                if (step_r == 2'd0)
                                    cmd_r <= (op_r == 3'(FSEC_OP_PROGRAM)) ? CMD_PROG_SETUP : CMD_ERASE_SETUP;
                                else if (step_r == 2'd1)
                                    cmd_r <= (op_r == 3'(FSEC_OP_PROGRAM)) ? data_r[7:0] : CMD_ERASE_GO;
                                else
                                begin
                                    rd_only_r <= 1'b1;
                                    state_r   <= S_RD_LO;
                                    cnt_r     <= 8'(CYC_RC);
                                end
                            end
                            FSEC_OP_CLEAR:  cmd_r <= CMD_CLEAR_STATUS;
                            FSEC_OP_READ:
                            begin
                                if (step_r == 2'd0)
                                    cmd_r <= CMD_READ_ARRAY;
                                else
                                begin
                                    state_r <= S_RD_LO;
                                    cnt_r   <= 8'(CYC_RC);
                                end
                            end
                            default:
                            begin
                                if (step_r == 2'd0)
                                    cmd_r <= CMD_READ_STATUS;
                                else
                                begin
                                    state_r <= S_RD_LO;
                                    cnt_r   <= 8'(CYC_RC);
                                end
                            end
                        endcase
                    end
                end
                // Write strobe low with address and data driven
                S_WR_LO:
                begin
                    flash_pins.addr    <= addr_r;
                    flash_pins.dq_out  <= (op_r == 3'(FSEC_OP_PROGRAM) && step_r == 2'd1) ? data_r : {8'h00, cmd_r};
                    flash_pins.dq_oe_n <= 1'b0;
                    flash_pins.we_n    <= 1'b0;
                    // Release after the full count so the strobe stays low CYC_WP cycles
                    if (cnt_r == 8'd0)
                    begin
                        flash_pins.we_n <= 1'b1;
                        cnt_r   <= 8'(CYC_WPH);
                        state_r <= S_WR_HI;
                    end
                end
                // Write strobe high recovery; engine runs on with chip select released
                S_WR_HI:
                begin
                    if (cnt_r == 8'd1)
                    begin
                        flash_pins.dq_oe_n <= 1'b1;
                        flash_pins.ce_n    <= 1'b1;
                        step_r  <= step_r + 2'd1;
                        state_r <= S_NEXT;
                        if (op_r == 3'(FSEC_OP_CLEAR))
                        begin
                            stat_r <= 8'h00;
                            step_r <= 2'd3;
                        end
                    end
                end
                // Output enable low, sample after the read cycle time
                S_RD_LO:
                begin
                    flash_pins.oe_n <= 1'b0;
                    if (cnt_r == 8'd1)
                    begin
                        flash_pins.oe_n <= 1'b1;
                        flash_pins.ce_n <= 1'b1;
                        state_r <= S_NEXT;
                        cnt_r   <= 8'(CYC_WPH);
                        if (rd_only_r || op_r == 3'(FSEC_OP_STATUS))
                        begin
                            stat_r <= dq_s2_r[7:0];
                            // Done once the idle flag reads one, or at once for a status operation
                            if (dq_s2_r[SB_IDLE] || op_r == 3'(FSEC_OP_STATUS))
                            begin
                                step_r <= 2'd3;
                            end
                        end
                        else
                        begin
                            rdata_r <= dq_s2_r;
                            step_r  <= 2'd3;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: testbench/fsec_checker.sv
// Concurrent checks on the flash pins of the flash host controller
`timescale 1ns/100ps
`default_nettype none
module fsec_checker
    import fsec_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire fsec_pins_s flash_pins
);
    localparam int WP_LAST = CYC_WP - 1; // Last low sample of a write strobe
    logic [8:0] low_cnt = 9'h000;        // Cycles the flash reset pin has been low

    // Count consecutive cycles with the flash reset pin low, saturating
    always_ff @(posedge aclk)
    begin
        if (flash_pins.reset_powerdown_n) low_cnt <= 9'h000;
        else if (low_cnt != 9'h1ff) low_cnt <= low_cnt + 9'h001;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Falling write strobe that carries one command code
    sequence cmd_s(logic [7:0] code);
        $fell(flash_pins.we_n) && flash_pins.dq_out[7:0] == code;
    endsequence

    // Start of a status poll read
    sequence poll_s;
        $fell(flash_pins.oe_n);
    endsequence

    rst_park_a: assert property (disable iff (1'b0) !aresetn |=> !flash_pins.reset_powerdown_n && flash_pins.ce_n)
        else $error("Flash pins not parked while reset is low");
    rp_width_a: assert property ($rose(flash_pins.reset_powerdown_n) |-> low_cnt >= CYC_RP)
        else $error("Flash reset pulse too short");
    rp_quiet_a: assert property (!flash_pins.reset_powerdown_n |-> flash_pins.we_n)
        else $error("Write strobe low while flash reset pin is low");
    wr_pulse_a: assert property ($fell(flash_pins.we_n) |-> ##WP_LAST (!flash_pins.we_n ##1 flash_pins.we_n))
        else $error("Write strobe low time wrong");
    wr_gap_a: assert property ($rose(flash_pins.we_n) |-> flash_pins.we_n [*8])
        else $error("Write strobe high time too short");
    wr_drive_a: assert property (!flash_pins.we_n |-> !flash_pins.dq_oe_n && !flash_pins.ce_n)
        else $error("Write cycle without data drive or chip select");
    erase_pair_a: assert property (cmd_s(CMD_ERASE_SETUP) |-> ##[1:100] cmd_s(CMD_ERASE_GO))
        else $error("Erase setup not followed by erase_go_cmd");
    erase_poll_a: assert property (cmd_s(CMD_ERASE_GO) |-> ##[1:100] poll_s)
        else $error("No status poll after erase_go_cmd");
    prog_poll_a: assert property (cmd_s(CMD_PROG_SETUP) ##[1:40] $fell(flash_pins.we_n) |-> ##[1:100] poll_s)
        else $error("No status poll after program data");
endmodule

bind fsec_ctrl fsec_checker u_chk (.aclk(aclk), .aresetn(aresetn), .flash_pins(flash_pins));
`default_nettype wire

// file: testbench/fsec_flash_model.sv
// Behavioural flash device: command decode, status flags, engine and power states
`timescale 1ns/100ps
`default_nettype none
module fsec_flash_model
    import fsec_pkg::*;
#(
    parameter int BUSY_CYC = 120 // Engine run time in clock cycles
)
(
    input  wire fsec_pins_s  pins,
    input  wire logic        aclk,
    input  wire logic        vpp_ok,
    input  wire logic        fail_inj,
    output var  logic [15:0] dq = 16'h0000,
    output var  logic        standby
);
    logic [7:0]  busy_cnt;   // Remaining engine cycles, zero when idle
    logic        s3, s4, s5; // Supply-missing, program-fail, erase-fail flags
    logic        st_mode;    // Status read mode instead of array read mode
    logic        is_erase;   // Running operation is an erase
    logic [1:0]  phase;      // 1 after program setup, 2 after erase setup
    logic        we_q;       // Write strobe one cycle ago
    logic [15:0] wd;         // Data latched while the strobe is low
    logic        rd_en;      // A read cycle selects the device

    assign rd_en = !pins.oe_n && !pins.ce_n && pins.reset_powerdown_n;
    assign standby = pins.ce_n && busy_cnt == 8'h00 && pins.reset_powerdown_n;

    // Read data; a released bus shows a pattern that changes every cycle
    always @(posedge aclk)
    begin
        if (rd_en && (st_mode || busy_cnt != 8'h00)) dq <= {8'h00, busy_cnt == 8'h00, 1'b0, s5, s4, s3, 3'b000};
        else if (rd_en) dq <= ~pins.addr[15:0];
        else dq <= ~dq;
    end

    // Command decoder and engine; a low reset pin aborts the engine and clears the flags, status mode and phase
    always @(posedge aclk)
    begin
        we_q <= pins.we_n;
        if (!pins.we_n && !pins.ce_n) wd <= pins.dq_out;
        if (!pins.reset_powerdown_n) {busy_cnt, s3, s4, s5, st_mode, phase} <= '0;
        else if (busy_cnt != 8'h00)
        begin
            busy_cnt <= busy_cnt - 8'h01;
            if (busy_cnt == 8'h01 && is_erase) s5 <= s5 | fail_inj;
            if (busy_cnt == 8'h01 && !is_erase) s4 <= s4 | fail_inj;
        end
        else if (pins.we_n && !we_q)
        begin
            phase <= 2'd0;
            if (phase != 2'd0) st_mode <= 1'b1;
            if (phase == 2'd2 && wd[7:0] != CMD_ERASE_GO) {s5, s4} <= 2'b11;
            else if (phase != 2'd0 && !s3 && !vpp_ok) s3 <= 1'b1;
            else if (phase != 2'd0 && !s3) {busy_cnt, is_erase} <= {8'(BUSY_CYC), phase == 2'd2};
            else if (phase == 2'd0)
                case (wd[7:0])
                    CMD_READ_ARRAY:   st_mode <= 1'b0;
                    CMD_READ_STATUS:  st_mode <= 1'b1;
                    CMD_CLEAR_STATUS: {s3, s4, s5} <= 3'b000;
                    CMD_PROG_SETUP:   phase <= 2'd1;
                    CMD_ERASE_SETUP:  phase <= 2'd2;
                    default:          st_mode <= st_mode;
                endcase
        end
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Testbench: AXI4-Lite register accesses to the flash host controller with a flash model
`timescale 1ns/100ps
`default_nettype none
module testbench
    import fsec_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, vpp_ok, fail_inj;
    logic        awready, wready, bvalid, arready, rvalid, standby;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] dq;
    fsec_pins_s  pins;
    int          failures = 0;
    int          comparisons = 0;
    // Steps: {op, supply present, fail verify, expected error decode}
    logic [7:0]  steps [15] = '{8'h10, 8'h01, 8'h50, 8'h1a, 8'h03, 8'h13, 8'h50, 8'h3c, 8'h25, 8'h50,
                                8'h1a, 8'h3e, 8'h07, 8'h50, 8'h90};

    fsec_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
        .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .flash_pins(pins), .flash_dq_in(dq));
    fsec_flash_model #(.BUSY_CYC(120)) u_flash (.pins(pins), .aclk(aclk), .vpp_ok(vpp_ok), .fail_inj(fail_inj),
        .dq(dq), .standby(standby));

    // Free-running 250 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Print counts and verdict, then stop
    task automatic wrap_up();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // A wait that ran out ends the run
    task automatic timeout();
        failures++;
        $display("[FAIL] %0t wait ran out", $time);
        wrap_up();
    endtask

    // Compare a seen value with the expected one
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One AXI4-Lite write; address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int   n;
        logic got;
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        {n, got, resp} = '0;
        while (!got && n < 300)
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) {got, resp} = {1'b1, bresp};
        end
        bready <= 1'b0;
        if (!got) timeout();
        @(posedge aclk);
    endtask

    // One AXI4-Lite read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int   n;
        logic got;
        {araddr, arvalid, rready} <= {a, 2'b11};
        {n, got, d, resp} = '0;
        while (!got && n < 300)
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) {got, d, resp} = {1'b1, rdata, rresp};
        end
        rready <= 1'b0;
        if (!got) timeout();
        @(posedge aclk);
    endtask

    // Start one operation and poll the status register until done
    task automatic run_op(input logic [2:0] op, input logic vpp, input logic fail, output logic [31:0] st);
        int         n;
        logic [1:0] r;
        {vpp_ok, fail_inj} <= {vpp, fail};
        axi_wr(OFS_CTRL, {28'h0000000, op, 1'b1}, r);
        st = RST_ZERO;
        for (n = 0; n < 100 && st[9] !== 1'b1; n++) axi_rd(OFS_STATUS, st, r);
        if (st[9] !== 1'b1) timeout();
    endtask

    // Main sequence
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, fail_inj, awaddr, araddr, wdata} = '0;
        {vpp_ok, aresetn} = 2'b10;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        check(pins.reset_powerdown_n, 1'b0);
        repeat (300) @(posedge aclk);
        check(pins.reset_powerdown_n, 1'b1);
        axi_rd(OFS_CTRL, rd, rs);
        check(rd, RST_ZERO);
        axi_rd(OFS_STATUS, rd, rs);
        check(rd, RST_ZERO);
        axi_wr(8'h14, 32'h0000_0001, rs);
        check(rs, 2'b10);
        axi_rd(8'h02, rd, rs);
        check(rs, 2'b10);
        axi_wr(OFS_ADDR, 32'h0000_0123, rs);
        axi_wr(OFS_DATA, 32'h0000_a5c3, rs);
        for (int i = 0; i < 15; i++)
        begin
            run_op(steps[i][7:5], steps[i][4], steps[i][3], rd);
            check(rd[12:10], steps[i][2:0]);
            check(rd[7:0], steps[i][7:5] == 3'd2 ? 8'h00 : {2'b10, steps[i][2:0], 3'b000});
            check(u_flash.busy_cnt, 8'h00);
        end
        check(standby, 1'b1);
        run_op(3'd3, 1'b1, 1'b0, rd);
        axi_rd(OFS_RDATA, rd, rs);
        check(rd[15:0], 16'hfedc);
        run_op(3'd0, 1'b0, 1'b0, rd);
        check(rd[12:10], 3'b001);
        axi_wr(OFS_CTRL, 32'h0000_0010, rs);
        repeat (50) @(posedge aclk);
        check(pins.reset_powerdown_n, 1'b0);
        axi_wr(OFS_CTRL, RST_ZERO, rs);
        repeat (400) @(posedge aclk);
        run_op(3'd4, 1'b1, 1'b0, rd);
        check(rd[7:0], 8'h80);
        wrap_up();
    end
endmodule
`default_nettype wire
